/* design/pump_derag_lube_sequencer.sv */
`timescale 1ns/10ps
module pump_derag_lube_sequencer #(
  parameter int unsigned TICK_CYCLES = lube_derag_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // drive control
  input wire logic run_cmd,
  input wire logic motor_stopped,
  input wire logic seq_action,
  input wire logic timed_action,
  input wire logic high_power,
  input wire logic derag_din,
  // motor command
  output logic drive_run,
  output logic dir_rev,
  output logic derag_speed,
  output logic coast,
  // status and device outputs
  output logic derag_active,
  output logic derag_dout,
  output logic lube_out
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_START_DLY, ST_RUN, ST_STOPPING, ST_OFF_INIT, ST_REV, ST_GAP, ST_FWD
  } seq_state_type;

  function automatic logic [9:0] clamp_secs(input logic [31:0] v);
    clamp_secs = (v > 32'(lube_derag_pkg::SECS_MAX)) ? lube_derag_pkg::SECS_MAX : v[9:0];
  endfunction
  function automatic logic in_event(input seq_state_type s);
    in_event = s inside {ST_STOPPING, ST_OFF_INIT, ST_REV, ST_GAP, ST_FWD};
  endfunction

  logic [31:0] ctrl_r, status;
  logic [7:0] cyc_cfg_r, cyc_cnt_r;
  logic [9:0] off_cfg_r, run_cfg_r, pre_cfg_r, post_cfg_r, sdly_cfg_r;
  logic [lube_derag_pkg::NUM_TMR-1:0] ld, busy;
  logic [9:0] tsecs [lube_derag_pkg::NUM_TMR];
  seq_state_type state_r, state_nxt;
  logic cyc_inc, cyc_clr, next_rev_r;
  logic run_d_r, start_rise, stop_fall;
  logic din_s1_r, din_s2_r, din_s3_r, din_lvl_r, din_rise;
  logic [5:0] trig_src;
  logic tick, trig, lube_hold_r, hold_clr, lube_nxt;
  lube_derag_pkg::lube_mode_type mode;

  assign mode = lube_derag_pkg::lube_mode_type'(ctrl_r[lube_derag_pkg::CTRL_MODE_LO +: 2]);

  // register writes; durations saturate at the top of range
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= lube_derag_pkg::CTRL_RST;
      cyc_cfg_r <= lube_derag_pkg::DERAG_CYC_RST;
      off_cfg_r <= lube_derag_pkg::DERAG_OFF_RST;
      run_cfg_r <= lube_derag_pkg::DERAG_RUN_RST;
      pre_cfg_r <= lube_derag_pkg::PRE_LUBE_RST;
      post_cfg_r <= lube_derag_pkg::POST_LUBE_RST;
      sdly_cfg_r <= lube_derag_pkg::START_DLY_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        lube_derag_pkg::CTRL_OFS: ctrl_r <= {21'h000000, reg_wdata[10:0]};
        lube_derag_pkg::DERAG_CYC_OFS: cyc_cfg_r <= reg_wdata[7:0];
        lube_derag_pkg::DERAG_OFF_OFS: off_cfg_r <= clamp_secs(reg_wdata);
        lube_derag_pkg::DERAG_RUN_OFS: run_cfg_r <= clamp_secs(reg_wdata);
        lube_derag_pkg::PRE_LUBE_OFS: pre_cfg_r <= clamp_secs(reg_wdata);
        lube_derag_pkg::POST_LUBE_OFS: post_cfg_r <= clamp_secs(reg_wdata);
        lube_derag_pkg::START_DLY_OFS: sdly_cfg_r <= clamp_secs(reg_wdata);
        default: ;
      endcase
    end
  end

  always_comb
  begin
    status = 32'h0000_0000;
    status[lube_derag_pkg::STAT_LUBE] = lube_out;
    status[lube_derag_pkg::STAT_RUN] = drive_run;
    status[lube_derag_pkg::STAT_REV] = dir_rev;
    status[lube_derag_pkg::STAT_COAST] = coast;
    status[lube_derag_pkg::STAT_CYC_LO +: 8] = cyc_cnt_r;
    status[lube_derag_pkg::STAT_DERAG] = derag_active;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        lube_derag_pkg::CTRL_OFS: reg_rdata <= ctrl_r;
        lube_derag_pkg::DERAG_CYC_OFS: reg_rdata <= {24'h000000, cyc_cfg_r};
        lube_derag_pkg::DERAG_OFF_OFS: reg_rdata <= {22'h000000, off_cfg_r};
        lube_derag_pkg::DERAG_RUN_OFS: reg_rdata <= {22'h000000, run_cfg_r};
        lube_derag_pkg::PRE_LUBE_OFS: reg_rdata <= {22'h000000, pre_cfg_r};
        lube_derag_pkg::POST_LUBE_OFS: reg_rdata <= {22'h000000, post_cfg_r};
        lube_derag_pkg::START_DLY_OFS: reg_rdata <= {22'h000000, sdly_cfg_r};
        lube_derag_pkg::EXT_STATUS_OFS: reg_rdata <= status;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // pin input: a level counts once two later stages agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      din_s3_r <= 1'b0;
      din_lvl_r <= 1'b0;
    end
    else
    begin
      din_s1_r <= derag_din;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
      if (din_s2_r == din_s3_r)
        din_lvl_r <= din_s3_r;
    end
  end

  assign din_rise = din_s2_r && din_s3_r && !din_lvl_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      run_d_r <= 1'b0;
    else
      run_d_r <= run_cmd;
  end

  assign start_rise = run_cmd && !run_d_r;
  assign stop_fall = !run_cmd && run_d_r;

  assign trig_src[lube_derag_pkg::TRIG_START] = start_rise;
  assign trig_src[lube_derag_pkg::TRIG_STOP] = stop_fall;
  assign trig_src[lube_derag_pkg::TRIG_DIN] = din_rise;
  assign trig_src[lube_derag_pkg::TRIG_SEQ] = seq_action;
  assign trig_src[lube_derag_pkg::TRIG_TIMED] = timed_action;
  assign trig_src[lube_derag_pkg::TRIG_POWER] = high_power;
  // triggers arriving mid event are dropped, not queued
  assign trig = ctrl_r[lube_derag_pkg::CTRL_DERAG_EN]
    && |(trig_src & ctrl_r[lube_derag_pkg::CTRL_TRIG_LO +: lube_derag_pkg::CTRL_TRIG_W]);

  sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  assign tsecs[lube_derag_pkg::T_SDLY] = sdly_cfg_r;
  assign tsecs[lube_derag_pkg::T_PRE] = pre_cfg_r;
  assign tsecs[lube_derag_pkg::T_POST] = post_cfg_r;
  assign tsecs[lube_derag_pkg::T_OFF] = off_cfg_r;
  assign tsecs[lube_derag_pkg::T_RUN] = run_cfg_r;

  sec_timer_if tif [lube_derag_pkg::NUM_TMR] ();

  generate
    for (genvar i = 0; i < lube_derag_pkg::NUM_TMR; i++)
    begin : g_tmr
      assign tif[i].load = ld[i];
      assign tif[i].secs = tsecs[i];
      assign busy[i] = tif[i].busy;
      sec_timer u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .t(tif[i])
      );
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    ld = '0;
    cyc_inc = 1'b0;
    cyc_clr = 1'b0;
    ld[lube_derag_pkg::T_PRE] = start_rise;
    ld[lube_derag_pkg::T_POST] = hold_clr;
    case (state_r)
      ST_IDLE, ST_START_DLY, ST_RUN:
      begin
        if (trig && motor_stopped)
        begin
          state_nxt = ST_REV;
          ld[lube_derag_pkg::T_RUN] = 1'b1;
          cyc_clr = 1'b1;
        end
        else if (trig)
          state_nxt = ST_STOPPING;
        else if (state_r == ST_IDLE && start_rise)
        begin
          state_nxt = ST_START_DLY;
          ld[lube_derag_pkg::T_SDLY] = 1'b1;
        end
        else if (state_r != ST_IDLE && !run_cmd)
          state_nxt = ST_IDLE;
        else if (state_r == ST_START_DLY && !busy[lube_derag_pkg::T_SDLY])
          state_nxt = ST_RUN;
      end
      ST_STOPPING:
      begin
        if (motor_stopped)
        begin
          state_nxt = ST_OFF_INIT;
          ld[lube_derag_pkg::T_OFF] = 1'b1;
        end
      end
      ST_OFF_INIT:
      begin
        if (!busy[lube_derag_pkg::T_OFF])
        begin
          state_nxt = ST_REV;
          ld[lube_derag_pkg::T_RUN] = 1'b1;
          cyc_clr = 1'b1;
        end
      end
      ST_REV:
      begin
        if (!busy[lube_derag_pkg::T_RUN])
        begin
          state_nxt = ST_GAP;
          ld[lube_derag_pkg::T_OFF] = 1'b1;
        end
      end
      ST_GAP:
      begin
        if (!busy[lube_derag_pkg::T_OFF])
        begin
          state_nxt = next_rev_r ? ST_REV : ST_FWD;
          ld[lube_derag_pkg::T_RUN] = 1'b1;
        end
      end
      ST_FWD:
      begin
        if (!busy[lube_derag_pkg::T_RUN])
        begin
          cyc_inc = 1'b1;
          // a zero cycle count still runs one cycle
          if (cyc_cnt_r + 8'h01 >= cyc_cfg_r)
            state_nxt = run_cmd ? ST_RUN : ST_IDLE;
          else
          begin
            state_nxt = ST_GAP;
            ld[lube_derag_pkg::T_OFF] = 1'b1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || cyc_clr)
      cyc_cnt_r <= 8'h00;
    else if (cyc_inc)
      cyc_cnt_r <= cyc_cnt_r + 8'h01;
  end

  // direction for the pulse after the coming gap
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      next_rev_r <= 1'b0;
    else if (state_r == ST_REV)
      next_rev_r <= 1'b0;
    else if (state_r == ST_FWD)
      next_rev_r <= 1'b1;
  end

  // outputs follow the next state so they line up with it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      drive_run <= 1'b0;
      dir_rev <= 1'b0;
      derag_speed <= 1'b0;
      coast <= 1'b0;
      derag_active <= 1'b0;
      derag_dout <= 1'b0;
    end
    else
    begin
      drive_run <= state_nxt == ST_RUN || state_nxt == ST_REV || state_nxt == ST_FWD;
      dir_rev <= state_nxt == ST_REV;
      derag_speed <= state_nxt == ST_REV || state_nxt == ST_FWD;
      coast <= state_nxt == ST_GAP || state_nxt == ST_OFF_INIT;
      derag_active <= in_event(state_nxt);
      derag_dout <= ctrl_r[lube_derag_pkg::CTRL_DOUT_EN] && in_event(state_nxt);
    end
  end

  // hold from run rise until the motor has really come to rest
  assign hold_clr = lube_hold_r && !run_cmd && !start_rise && motor_stopped && state_r == ST_IDLE
    && mode == lube_derag_pkg::LUBE_PRE_RUN_POST;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lube_hold_r <= 1'b0;
    else if (start_rise)
      lube_hold_r <= 1'b1;
    else if (!run_cmd && motor_stopped && state_r == ST_IDLE)
      lube_hold_r <= 1'b0;
  end

  always_comb
  begin
    case (mode)
      lube_derag_pkg::LUBE_PRE: lube_nxt = busy[lube_derag_pkg::T_PRE];
      lube_derag_pkg::LUBE_PRE_RUN: lube_nxt = lube_hold_r;
      lube_derag_pkg::LUBE_PRE_RUN_POST: lube_nxt = lube_hold_r || busy[lube_derag_pkg::T_POST];
      default: lube_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lube_out <= 1'b0;
    else
      lube_out <= lube_nxt;
  end
endmodule

/* design/lube_derag_pkg.sv */
package lube_derag_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned TICK_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned SECS_W = 10;
  localparam logic [9:0] SECS_MAX = 10'h258;
  localparam logic [9:0] PRE_LUBE_RST = 10'h00A;
  localparam logic [9:0] POST_LUBE_RST = 10'h00A;
  localparam logic [9:0] START_DLY_RST = 10'h000;
  localparam logic [9:0] DERAG_OFF_RST = 10'h005;
  localparam logic [9:0] DERAG_RUN_RST = 10'h005;
  localparam logic [7:0] DERAG_CYC_RST = 8'h01;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] DERAG_CYC_OFS = 5'h04;
  localparam logic [4:0] DERAG_OFF_OFS = 5'h08;
  localparam logic [4:0] DERAG_RUN_OFS = 5'h0C;
  localparam logic [4:0] PRE_LUBE_OFS = 5'h10;
  localparam logic [4:0] POST_LUBE_OFS = 5'h14;
  localparam logic [4:0] START_DLY_OFS = 5'h18;
  localparam logic [4:0] EXT_STATUS_OFS = 5'h1C;
  // control fields
  localparam int unsigned CTRL_DERAG_EN = 0;
  localparam int unsigned CTRL_TRIG_LO = 1;
  localparam int unsigned CTRL_TRIG_W = 6;
  localparam int unsigned CTRL_MODE_LO = 8;
  localparam int unsigned CTRL_DOUT_EN = 10;
  // trigger select bits within the trigger field
  localparam int unsigned TRIG_START = 0;
  localparam int unsigned TRIG_STOP = 1;
  localparam int unsigned TRIG_DIN = 2;
  localparam int unsigned TRIG_SEQ = 3;
  localparam int unsigned TRIG_TIMED = 4;
  localparam int unsigned TRIG_POWER = 5;
  // extended status fields
  localparam int unsigned STAT_LUBE = 0;
  localparam int unsigned STAT_RUN = 1;
  localparam int unsigned STAT_REV = 2;
  localparam int unsigned STAT_COAST = 3;
  localparam int unsigned STAT_CYC_LO = 8;
  localparam int unsigned STAT_DERAG = 23;
  // timer slots
  localparam int unsigned NUM_TMR = 5;
  localparam int unsigned T_SDLY = 0;
  localparam int unsigned T_PRE = 1;
  localparam int unsigned T_POST = 2;
  localparam int unsigned T_OFF = 3;
  localparam int unsigned T_RUN = 4;
  typedef enum logic [1:0] {LUBE_OFF, LUBE_PRE, LUBE_PRE_RUN, LUBE_PRE_RUN_POST} lube_mode_type;
endpackage

/* design/sec_timer_if.sv */
`timescale 1ns/10ps
interface sec_timer_if;
  logic load;
  logic [9:0] secs;
  logic busy;
  modport owner (output load, output secs, input busy);
  modport timer (input load, input secs, output busy);
endinterface

/* design/sec_tick.sv */
`timescale 1ns/10ps
module sec_tick #(
  parameter int unsigned CYCLES = lube_derag_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // one pulse per second
  output logic tick
);
  logic [25:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= 26'h0000000;
      tick <= 1'b0;
    end
    else if (cnt_r == 26'(CYCLES - 1))
    begin
      cnt_r <= 26'h0000000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 26'h0000001;
      tick <= 1'b0;
    end
  end
endmodule

/* design/sec_timer.sv */
`timescale 1ns/10ps
module sec_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // shared second tick
  input wire logic tick,
  // owner side
  sec_timer_if.timer t
);
  logic [9:0] remain_r;

  // a fresh load always wins, so a repeated start restarts the count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      remain_r <= 10'h000;
    else if (t.load)
      remain_r <= t.secs;
    else if (tick && remain_r != 10'h000)
      remain_r <= remain_r - 10'h001;
  end

  assign t.busy = (remain_r != 10'h000);
endmodule

/* tb/seq_assertions.sv */
`timescale 1ns/10ps
module seq_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // motor side
  input wire logic motor_stopped,
  input wire logic drive_run,
  input wire logic dir_rev,
  input wire logic derag_speed,
  input wire logic coast,
  // status outputs
  input wire logic derag_active,
  input wire logic derag_dout,
  input wire logic lube_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rev_end;
    derag_active && dir_rev ##1 !dir_rev;
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 5'h1C;
  endsequence
  property p_rev_in_pulse;
    dir_rev |-> drive_run && derag_speed && derag_active;
  endproperty
  a_rev_in_pulse: assert property (p_rev_in_pulse)
    else $error("reverse drive outside a clearing pulse");
  property p_speed_pulse;
    derag_speed |-> drive_run && derag_active;
  endproperty
  a_speed_pulse: assert property (p_speed_pulse)
    else $error("clearing speed outside an event");
  property p_rev_gap;
    s_rev_end |-> coast && !drive_run;
  endproperty
  a_rev_gap: assert property (p_rev_gap)
    else $error("no coast gap after reverse pulse");
  property p_coast_idle;
    coast |-> !drive_run && !derag_speed && derag_active;
  endproperty
  a_coast_idle: assert property (p_coast_idle)
    else $error("drive applied while coasting");
  property p_fwd_last;
    $fell(derag_active) && $past(rst_n) |-> $past(derag_speed) && !$past(dir_rev);
  endproperty
  a_fwd_last: assert property (p_fwd_last)
    else $error("event did not end on a forward pulse");
  property p_stop_first;
    $rose(derag_active) && $past(drive_run) && $past(rst_n) |-> !drive_run && !coast && !dir_rev;
  endproperty
  a_stop_first: assert property (p_stop_first)
    else $error("running trigger did not stop the motor first");
  property p_no_first_gap;
    $rose(derag_active) && $past(motor_stopped) && !$past(drive_run) && $past(rst_n) |-> dir_rev;
  endproperty
  a_no_first_gap: assert property (p_no_first_gap)
    else $error("stopped trigger did not start with reverse");
  property p_status_rd;
    s_stat_rd |=> reg_rdata[23] == $past(derag_active) && reg_rdata[1:0] == {$past(drive_run), $past(lube_out)};
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status word disagrees with outputs");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
  property p_dout_mirror;
    derag_dout |-> derag_active;
  endproperty
  a_dout_mirror: assert property (p_dout_mirror)
    else $error("mirror output without active event");
endmodule

bind pump_derag_lube_sequencer seq_assertions chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .motor_stopped(motor_stopped), .drive_run(drive_run), .dir_rev(dir_rev), .derag_speed(derag_speed),
  .coast(coast), .derag_active(derag_active), .derag_dout(derag_dout), .lube_out(lube_out)
);

/* tb/motor_model.sv */
`timescale 1ns/10ps
module motor_model #(
  parameter int unsigned RAMP_CYCLES = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // drive command and speed feedback
  input wire logic drive_run,
  output logic motor_stopped
);
  logic [7:0] ramp_r;
  // speed decays a few cycles after drive is removed, so stop is never instant
  always_ff @(posedge clk)
  begin
    if (!rst_n || drive_run)
      ramp_r <= RAMP_CYCLES[7:0];
    else if (ramp_r != 8'h00)
      ramp_r <= ramp_r - 8'h01;
  end
  assign motor_stopped = (ramp_r == 8'h00);
endmodule

/* tb/pump_derag_lube_sequencer_tb.sv */
`timescale 1ns/10ps
module pump_derag_lube_sequencer_tb;
  typedef struct {logic [4:0] a; logic [31:0] d;} row_type;
  row_type rows [9] = '{'{5'h00, 32'h0}, '{5'h04, 32'h1}, '{5'h08, 32'h5}, '{5'h0C, 32'h5},
    '{5'h10, 32'hA}, '{5'h14, 32'hA}, '{5'h18, 32'h0}, '{5'h1C, 32'h0}, '{5'h1D, 32'h0}};
  logic clk, rst_n, reg_wr, reg_rd, run_cmd, seq_action, timed_action, high_power, derag_din;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_q;
  logic motor_stopped, drive_run, dir_rev, derag_speed, coast, derag_active, derag_dout, lube_out;
  logic rv = 1'b0;
  int err_count, n_tests, cyc, revs, base, k;

  // short second keeps every timed phase to a handful of cycles
  pump_derag_lube_sequencer #(.TICK_CYCLES(4)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_cmd(run_cmd), .motor_stopped(motor_stopped),
    .seq_action(seq_action), .timed_action(timed_action), .high_power(high_power), .derag_din(derag_din),
    .drive_run(drive_run), .dir_rev(dir_rev), .derag_speed(derag_speed), .coast(coast),
    .derag_active(derag_active), .derag_dout(derag_dout), .lube_out(lube_out));
  motor_model motor (.clk(clk), .rst_n(rst_n), .drive_run(drive_run), .motor_stopped(motor_stopped));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    rv <= dir_rev;
    if (dir_rev && !rv)
      revs <= revs + 1;
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask

  initial
  begin
    {rst_n, reg_wr, reg_rd, run_cmd, seq_action, timed_action, high_power, derag_din} = 8'h00;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk_reg("reset value", rows[i].d, rd_q);
    end
    wr(5'h10, 32'h3E8);
    rd(5'h10);
    chk_reg("pre lube limit", 32'h258, rd_q);
    wr(5'h14, 32'h259);
    rd(5'h14);
    chk_reg("post lube limit", 32'h258, rd_q);
    wr(5'h04, 32'h2);
    wr(5'h08, 32'h1);
    wr(5'h0C, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      wr(5'h00, 32'h401 | (32'h2 << i));
      // stop trigger needs a running motor first
      if (i == 1)
      begin
        run_cmd <= 1'b1;
        repeat (20) @(posedge clk);
      end
      base = revs;
      @(posedge clk);
      case (i)
        0: run_cmd <= 1'b1;
        1: run_cmd <= 1'b0;
        2: derag_din <= 1'b1;
        3: seq_action <= 1'b1;
        4: timed_action <= 1'b1;
        default: high_power <= 1'b1;
      endcase
      @(posedge clk);
      {seq_action, timed_action, high_power} <= 3'h0;
      for (k = 0; k < 40 && derag_active !== 1'b1; k++) @(negedge clk);
      chk_bit("clearing started", 1'b1, derag_active);
      chk_bit("mirror output", 1'b1, derag_dout);
      rd(5'h1C);
      chk_reg("active flag", 32'h80_0000, rd_q & 32'h80_0000);
      for (k = 0; k < 400 && derag_active === 1'b1; k++) @(negedge clk);
      chk_bit("clearing ended", 1'b0, derag_active);
      chk_reg("reverse pulses", 32'h2, 32'(revs - base));
      @(posedge clk);
      run_cmd <= 1'b0;
      derag_din <= 1'b0;
      repeat (30) @(posedge clk);
    end
    wr(5'h00, 32'h10);
    @(posedge clk);
    seq_action <= 1'b1;
    @(posedge clk);
    seq_action <= 1'b0;
    repeat (10) @(negedge clk);
    chk_bit("disabled clearing", 1'b0, derag_active);
    // start delay shorter than pre lube, so lube ends during ramp-up
    wr(5'h18, 32'h1);
    wr(5'h10, 32'h2);
    wr(5'h14, 32'h4);
    for (int m = 0; m < 4; m++)
    begin
      wr(5'h00, 32'(m) << 8);
      @(posedge clk);
      run_cmd <= 1'b1;
      repeat (3) @(negedge clk);
      chk_bit("lube at start", m != 0, lube_out);
      repeat (16) @(negedge clk);
      chk_bit("motor started", 1'b1, drive_run);
      chk_bit("lube while running", m >= 2, lube_out);
      @(posedge clk);
      run_cmd <= 1'b0;
      repeat (12) @(negedge clk);
      chk_bit("lube after stop", m == 3, lube_out);
      repeat (40) @(negedge clk);
      chk_bit("lube idle", 1'b0, lube_out);
    end
    // reset in mid event: the flag drops and the settings return to defaults
    wr(5'h00, 32'h411);
    @(posedge clk);
    seq_action <= 1'b1;
    @(posedge clk);
    seq_action <= 1'b0;
    @(negedge clk);
    chk_bit("event before reset", 1'b1, derag_active);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_bit("reset clears active", 1'b0, derag_active);
    rd(5'h10);
    chk_reg("pre lube default", 32'hA, rd_q);
    summarize();
  end
endmodule
